// ==== inc/hall_commutation_pkg.sv ====
// shared constants and types for the hall commutation block
package hall_commutation_pkg;

    // commutation steps: a..f high-side modulation, g..l low-side modulation
    typedef enum logic [3:0] {
        STEP_A = 4'h0,
        STEP_B = 4'h1,
        STEP_C = 4'h2,
        STEP_D = 4'h3,
        STEP_E = 4'h4,
        STEP_F = 4'h5,
        STEP_G = 4'h6,
        STEP_H = 4'h7,
        STEP_I = 4'h8,
        STEP_J = 4'h9,
        STEP_K = 4'ha,
        STEP_L = 4'hb
    } step_type;

    localparam step_type STEP_RESET = STEP_A;
    localparam step_type STEP_LAST = STEP_L;
    localparam step_type STEP_FIRST_LOW_SIDE = STEP_G;

    // brake action encodings
    localparam logic [1:0] BRAKE_LOW_SIDE = 2'h0;
    localparam logic [1:0] BRAKE_HIGH_SIDE = 2'h1;
    localparam logic [1:0] BRAKE_ALTERNATE = 2'h2;
    localparam logic [1:0] BRAKE_HIGH_Z = 2'h3;

    localparam logic FREEWHEEL_ACTIVE = 1'h1;
    localparam logic FREEWHEEL_DIODE = 1'h0;

    localparam logic [2:0] HALL_FORBIDDEN_LOW = 3'h0;
    localparam logic [2:0] HALL_FORBIDDEN_HIGH = 3'h7;
    localparam logic [2:0] HALL_RESET = 3'h0;
    localparam logic BRAKE_IDLE_RESET = 1'h1;
    localparam logic BRAKE_HIGH_RESET = 1'h0;

    localparam logic [1:0] PHASE_A = 2'h0;
    localparam logic [1:0] PHASE_B = 2'h1;
    localparam logic [1:0] PHASE_C = 2'h2;

    localparam int DEAD_TIME_WIDTH = 8;

    // returns {modulated phase, return phase} for a hall code and sense
    function automatic logic [3:0] conducting_pair(input logic [2:0] hall, input logic sense);
        logic [3:0] pair;
        pair = {PHASE_A, PHASE_A};
        unique case (hall)
            3'h5: pair = sense ? {PHASE_A, PHASE_C} : {PHASE_C, PHASE_A};
            3'h4: pair = sense ? {PHASE_B, PHASE_C} : {PHASE_C, PHASE_B};
            3'h6: pair = sense ? {PHASE_B, PHASE_A} : {PHASE_A, PHASE_B};
            3'h2: pair = sense ? {PHASE_C, PHASE_A} : {PHASE_A, PHASE_C};
            3'h3: pair = sense ? {PHASE_C, PHASE_B} : {PHASE_B, PHASE_C};
            3'h1: pair = sense ? {PHASE_A, PHASE_B} : {PHASE_B, PHASE_A};
            default: pair = {PHASE_A, PHASE_A};
        endcase
        return pair;
    endfunction

endpackage

// ==== rtl/dead_time_phase.sv ====
// one half-bridge: gate requests in, dead-time separated gate drives out
`timescale 1ns/100ps
module dead_time_phase #(
    parameter int DT_WIDTH = hall_commutation_pkg::DEAD_TIME_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic high_request,
    input wire logic low_request,
    input wire logic [DT_WIDTH-1:0] dead_time_rising,
    input wire logic [DT_WIDTH-1:0] dead_time_falling,
    output logic high_gate,
    output logic low_gate
);
    import hall_commutation_pkg::*;

    typedef struct packed {
        logic high;
        logic low;
        logic [DT_WIDTH-1:0] idle_count;
    } phase_type;

    phase_type phase_reg;
    phase_type phase_next;

    // switching off is immediate, switching on waits out the dead time;
    // at least one idle cycle always separates the two gates
    always_comb begin
        phase_next = phase_reg;
        phase_next.high = phase_reg.high & high_request;
        phase_next.low = phase_reg.low & low_request;
        if (phase_reg.high || phase_reg.low) begin
            phase_next.idle_count = '0;
        end else begin
            if (phase_reg.idle_count != '1) begin
                phase_next.idle_count = phase_reg.idle_count + 1'b1;
            end
            if (high_request && !low_request && phase_reg.idle_count >= dead_time_rising) begin
                phase_next.high = 1'b1;
            end
            if (low_request && !high_request && phase_reg.idle_count >= dead_time_falling) begin
                phase_next.low = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_reg <= '{high: 1'b0, low: 1'b0, idle_count: '1};
        end else begin
            phase_reg <= phase_next;
        end
    end

    a_gates_exclusive: assert property ( // [RULE18]
        @(posedge clock) disable iff (rst)
        !(phase_reg.high && phase_reg.low)
    ) else $error("both gates of one phase on");

    a_rise_after_dead: assert property ( // [RULE18]
        @(posedge clock) disable iff (rst)
        $rose(phase_reg.high) |-> $past(phase_reg.idle_count) >= $past(dead_time_rising)
    ) else $error("high gate on before rising dead time");

    a_fall_after_dead: assert property ( // [RULE18]
        @(posedge clock) disable iff (rst)
        $rose(phase_reg.low) |-> $past(phase_reg.idle_count) >= $past(dead_time_falling)
    ) else $error("low gate on before falling dead time");

    assign high_gate = phase_reg.high;
    assign low_gate = phase_reg.low;

endmodule // dead_time_phase

// ==== rtl/hall_commutation_alt_recirculation.sv ====
// hall driven single-pwm commutation with alternating recirculation
// Overview of operation
// RULE1 - freewheeling alternates between high-side and low-side switches each rotation
// RULE2 - first rotation: driven phase high gate pwm, return phase low gate on
// RULE3 - second rotation: return low gate pwm, driven phase high gate on; repeats
// RULE4 - twelve steps: a..f high-side modulation, g..l low-side modulation
// RULE5 - after step l the next transition returns to step a
// RULE6 - freewheel_select picks active or diode freewheeling
// RULE7 - diode freewheeling holds every inverted-pwm gate low
// RULE8 - sense one, high-side modulation: fixed pattern per hall code
// RULE9 - sense one, low-side modulation: fixed pattern per hall code
// RULE10 - sense zero, high-side modulation: fixed pattern per hall code
// RULE11 - sense zero, low-side modulation: fixed pattern per hall code
// RULE12 - both gates low leaves a phase floating
// RULE13 - low brake request overrides hall pattern with configured brake action
// RULE14 - hall codes 111 or 000 without brake drive all gates low
// RULE15 - six valid hall transitions end a rotation and swap modulation group
// RULE16 - controller supplies pwm timing whose duty and frequency are reproduced
// RULE17 - hall inputs select pattern, turn_sense gives rotation sense
// RULE18 - dead time inserted between complementary gates using programmed values
`timescale 1ns/100ps
module hall_commutation_alt_recirculation #(
    parameter int DT_WIDTH = hall_commutation_pkg::DEAD_TIME_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic pwm_timing_input,
    input wire logic turn_sense,
    input wire logic [2:0] hall_position_inputs,
    input wire logic brake_request_n,
    input wire logic freewheel_select,
    input wire logic [1:0] brake_select,
    input wire logic [DT_WIDTH-1:0] dead_time_rising,
    input wire logic [DT_WIDTH-1:0] dead_time_falling,
    output logic [2:0] high_gate_out,
    output logic [2:0] low_gate_out,
    output logic [2:0] phase_floating,
    output hall_commutation_pkg::step_type commutation_step,
    output logic low_side_modulation
);
    import hall_commutation_pkg::*;

    typedef struct packed {
        step_type step;
        logic [2:0] hall_last;
        logic brake_idle;
        logic brake_high;
        logic low_group;
    } ctrl_type;

    ctrl_type ctrl_reg;
    ctrl_type ctrl_next;

    logic hall_valid;
    logic hall_change;
    logic brake_event;
    logic brake_high_now;
    logic group_low;
    logic pwm_inverted;
    logic [3:0] pair;
    logic [1:0] mod_phase;
    logic [1:0] ret_phase;
    logic [2:0] high_request;
    logic [2:0] low_request;

    assign hall_valid = hall_position_inputs != HALL_FORBIDDEN_LOW
        && hall_position_inputs != HALL_FORBIDDEN_HIGH;
    // the first valid code after reset only seeds the reference
    assign hall_change = hall_valid && ctrl_reg.hall_last != HALL_RESET
        && hall_position_inputs != ctrl_reg.hall_last;
    // only a new brake event in alternate mode flips the braking side
    assign brake_event = ctrl_reg.brake_idle && !brake_request_n
        && brake_select == BRAKE_ALTERNATE;
    // toggle seen in the very cycle of a new brake event, not one later
    assign brake_high_now = brake_event ? !ctrl_reg.brake_high : ctrl_reg.brake_high;
    assign group_low = ctrl_reg.low_group; // [RULE1]
    assign pwm_inverted = (freewheel_select == FREEWHEEL_ACTIVE) & ~pwm_timing_input; // [RULE6]
    assign pair = conducting_pair(hall_position_inputs, turn_sense); // [RULE17]
    assign mod_phase = pair[3:2];
    assign ret_phase = pair[1:0];

    // step moves once per valid hall change; six changes make one rotation
    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next.brake_idle = brake_request_n;
        ctrl_next.brake_high = brake_high_now; // [RULE13]
        // forbidden codes keep the old reference, so a glitch costs no step
        if (hall_valid) begin
            ctrl_next.hall_last = hall_position_inputs;
        end
        if (hall_change) begin // [RULE4] [RULE15]
            if (ctrl_reg.step == STEP_LAST) begin // [RULE5]
                ctrl_next.step = STEP_A;
            end else begin
                ctrl_next.step = step_type'(4'(ctrl_reg.step) + 4'h1);
            end
        end
        ctrl_next.low_group = ctrl_next.step >= STEP_FIRST_LOW_SIDE; // [RULE1] [RULE3]
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg <= '{step: STEP_RESET, hall_last: HALL_RESET,
                brake_idle: BRAKE_IDLE_RESET, brake_high: BRAKE_HIGH_RESET,
                low_group: STEP_RESET >= STEP_FIRST_LOW_SIDE};
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // gate requests before dead time; brake wins over every hall pattern
    always_comb begin
        high_request = '0;
        low_request = '0;
        if (!brake_request_n) begin // [RULE13]
            unique case (brake_select)
                BRAKE_LOW_SIDE: begin
                    low_request = '1;
                end
                BRAKE_HIGH_SIDE: begin
                    high_request = '1;
                end
                BRAKE_ALTERNATE: begin
                    if (brake_high_now) begin
                        high_request = '1;
                    end else begin
                        low_request = '1;
                    end
                end
                BRAKE_HIGH_Z: begin
                    high_request = '0;
                    low_request = '0;
                end
            endcase
        end else if (hall_valid) begin
            if (!group_low) begin // [RULE2] [RULE8] [RULE10]
                high_request[mod_phase] = pwm_timing_input;
                low_request[mod_phase] = pwm_inverted; // [RULE7]
                low_request[ret_phase] = 1'b1;
            end else begin // [RULE3] [RULE9] [RULE11]
                high_request[mod_phase] = 1'b1;
                low_request[ret_phase] = pwm_timing_input;
                high_request[ret_phase] = pwm_inverted; // [RULE7]
            end
        end
        // forbidden codes fall through with every request off [RULE14]
    end

    // each half-bridge keeps its own idle timer [RULE18]
    for (genvar i = 0; i < 3; i++) begin : g_phase
        dead_time_phase #(
            .DT_WIDTH(DT_WIDTH)
        ) u_phase (
            .clock(clock),
            .rst(rst),
            .high_request(high_request[i]),
            .low_request(low_request[i]),
            .dead_time_rising(dead_time_rising),
            .dead_time_falling(dead_time_falling),
            .high_gate(high_gate_out[i]),
            .low_gate(low_gate_out[i])
        );
    end

    assign phase_floating = ~(high_gate_out | low_gate_out); // [RULE12]
    assign commutation_step = ctrl_reg.step; // [RULE4]
    assign low_side_modulation = ctrl_reg.low_group; // [RULE1]

    a_forbidden_all_low: assert property ( // [RULE14]
        @(posedge clock) disable iff (rst)
        brake_request_n && !hall_valid |=> high_gate_out == 3'h0 && low_gate_out == 3'h0
    ) else $error("forbidden hall code left a gate on");

    a_step_wraps: assert property ( // [RULE5]
        @(posedge clock) disable iff (rst)
        hall_change && ctrl_reg.step == STEP_LAST |=> ctrl_reg.step == STEP_A
    ) else $error("step did not return to a after l");

    a_step_advances: assert property ( // [RULE4] [RULE15]
        @(posedge clock) disable iff (rst)
        hall_change && ctrl_reg.step != STEP_LAST
            |=> 4'(ctrl_reg.step) == 4'($past(ctrl_reg.step)) + 4'h1
    ) else $error("step did not advance on a hall change");

    a_step_holds: assert property ( // [RULE15]
        @(posedge clock) disable iff (rst)
        !hall_change |=> $stable(ctrl_reg.step)
    ) else $error("step moved without a hall change");

    a_brake_high_z: assert property ( // [RULE13]
        @(posedge clock) disable iff (rst)
        !brake_request_n && brake_select == BRAKE_HIGH_Z
            |=> high_gate_out == 3'h0 && low_gate_out == 3'h0
    ) else $error("high impedance brake left a gate on");

    a_brake_low_side: assert property ( // [RULE13]
        @(posedge clock) disable iff (rst)
        !brake_request_n && brake_select == BRAKE_LOW_SIDE |=> high_gate_out == 3'h0
    ) else $error("low side brake left a high gate on");

    a_high_mod_pwm_low: assert property ( // [RULE2]
        @(posedge clock) disable iff (rst)
        brake_request_n && hall_valid && !group_low && !pwm_timing_input
            |=> high_gate_out == 3'h0
    ) else $error("high gate on while pwm low in high side group");

    a_low_mod_diode: assert property ( // [RULE3] [RULE7]
        @(posedge clock) disable iff (rst)
        brake_request_n && hall_valid && group_low && !pwm_timing_input
            && freewheel_select == FREEWHEEL_DIODE |=> low_gate_out == 3'h0
    ) else $error("low gate on while pwm low in diode low side group");

    c_group_swap: cover property (
        @(posedge clock) disable iff (rst) $rose(ctrl_reg.low_group));
    c_step_wrap: cover property (
        @(posedge clock) disable iff (rst) hall_change && ctrl_reg.step == STEP_LAST);
    c_alt_brake: cover property (
        @(posedge clock) disable iff (rst) brake_event);
    c_forbidden_code: cover property (
        @(posedge clock) disable iff (rst) brake_request_n && !hall_valid);

endmodule // hall_commutation_alt_recirculation

// ==== verification/hall_pwm_source.sv ====
// partner model: controller pwm source and three hall sensors
`timescale 1ns/100ps
module hall_pwm_source (
    input wire logic clock,
    input wire logic [2:0] position,
    input wire logic pwm_free,
    input wire logic pwm_level,
    output logic pwm_timing_input,
    output logic [2:0] hall_position_inputs
);
    // positions 6 and 7 give the two forbidden codes
    localparam logic [2:0] CODES [8] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h0, 3'h7};
    logic [3:0] count_reg = 4'h0;
    always_ff @(posedge clock) begin
        count_reg <= count_reg + 4'h1;
    end
    // duty of 5/16 while running, held level otherwise
    assign pwm_timing_input = pwm_free ? (count_reg < 4'h5) : pwm_level;
    assign hall_position_inputs = CODES[position];
endmodule // hall_pwm_source

// ==== verification/testbench.sv ====
// self-checking bench for the hall commutation block
`timescale 1ns/100ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    miscompares++; $display("unexpected %s expected %h seen %h", what, exp, got); end end
module testbench;
    import hall_commutation_pkg::*;
    logic clock = 1'b0, rst = 1'b1, pwm_free = 1'b0, pwm_level = 1'b0, sense = 1'b1;
    logic brake_n = 1'b1, fw = 1'b1, pwm, lsm;
    logic [1:0] bsel = 2'h0;
    logic [2:0] pos = 3'h0, hall, hg, lg, pf;
    logic brake_hi = BRAKE_HIGH_RESET;
    logic [7:0] dtr = 8'h02, dtf = 8'h03;
    logic [5:0] e;
    step_type step;
    int miscompares = 0, samples_checked = 0, moves = 0;
    always #4 clock = ~clock;
    hall_pwm_source u_src (.clock(clock), .position(pos), .pwm_free(pwm_free),
        .pwm_level(pwm_level), .pwm_timing_input(pwm), .hall_position_inputs(hall));
    hall_commutation_alt_recirculation u_dut (.clock(clock), .rst(rst),
        .pwm_timing_input(pwm), .turn_sense(sense), .hall_position_inputs(hall),
        .brake_request_n(brake_n), .freewheel_select(fw), .brake_select(bsel),
        .dead_time_rising(dtr), .dead_time_falling(dtf), .high_gate_out(hg),
        .low_gate_out(lg), .phase_floating(pf), .commutation_step(step),
        .low_side_modulation(lsm));
    // expected {high, low} gates for one position
    function automatic logic [5:0] gates(logic [2:0] p, logic s, logic lm, logic w, logic f);
        int mt[6] = '{0, 1, 1, 2, 2, 0};
        int rt[6] = '{2, 2, 0, 0, 1, 1};
        int m;
        int r;
        logic [2:0] hi = 3'h0;
        logic [2:0] lo = 3'h0;
        if (p > 3'h5) return 6'h00;
        m = s ? mt[p] : rt[p];
        r = s ? rt[p] : mt[p];
        if (!lm) begin
            hi[m] = w;
            lo[m] = f & ~w;
            lo[r] = 1'b1;
        end else begin
            hi[m] = 1'b1;
            lo[r] = w;
            hi[r] = f & ~w;
        end
        return {hi, lo};
    endfunction
    task automatic settle(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        final_report();
    end
    initial begin
        void'($urandom(90283));
        dtr = 8'($urandom_range(8, 1));
        dtf = 8'($urandom_range(8, 1));
        settle(4);
        rst = 1'b0;
        for (int s = 1; s >= 0; s--) begin
            sense = 1'(s);
            for (int k = 0; k < 26; k++) begin
                if (k > 0 || s == 0) begin
                    pos = (pos == 3'h5) ? 3'h0 : pos + 3'h1;
                    moves++;
                end
                pwm_free = 1'b1;
                fw = 1'($urandom);
                settle(10);
                pwm_free = 1'b0;
                pwm_level = 1'($urandom);
                settle(30);
                e = gates(pos, sense, 1'((moves / 6) % 2), pwm_level, fw);
                `CHK("gates", e, {hg, lg})
                `CHK("floating", ~(e[5:3] | e[2:0]), pf)
                `CHK("group", 1'((moves / 6) % 2), lsm)
                `CHK("step", step_type'(moves % 12), step)
            end
            $display("rotation test done");
        end
        for (int p = 6; p < 8; p++) begin
            pos = 3'(p);
            settle(30);
            `CHK("forbidden", 6'h00, {hg, lg})
        end
        pos = 3'h0;
        $display("forbidden test done");
        for (int b = 0; b < 5; b++) begin
            bsel = (b > 3) ? BRAKE_ALTERNATE : 2'(b);
            brake_n = 1'b0;
            if (bsel == BRAKE_ALTERNATE) brake_hi = ~brake_hi;
            settle(30);
            e = (bsel == BRAKE_LOW_SIDE) ? 6'h07 : (bsel == BRAKE_HIGH_SIDE) ? 6'h38 : 6'h00;
            if (bsel == BRAKE_ALTERNATE) e = brake_hi ? 6'h38 : 6'h07;
            `CHK("brake", e, {hg, lg})
            brake_n = 1'b1;
            settle(30);
        end
        $display("brake test done");
        final_report();
    end
endmodule // testbench
